// [acfg_pkg.sv]
// Constants, field layouts and types for the converter digital-path config
`default_nettype none
package acfg_pkg;
  // Register indices as printed; byte address is four times the index
  localparam logic [7:0] IDX_DOWNCONV_SETUP_BC  = 8'h00;
  localparam logic [7:0] IDX_PAIR_SETUP_BC      = 8'h01;
  localparam logic [7:0] IDX_PAIR_SETUP_AD      = 8'h02;
  localparam logic [7:0] IDX_INTERLEAVE_FIX     = 8'h18;
  localparam logic [7:0] IDX_QUAD_UNLOCK_REST   = 8'h40;
  localparam logic [7:0] IDX_OFFSET_LOOP_CTRL   = 8'h68;
  localparam logic [7:0] IDX_TEST_PATTERN_SEL   = 8'h74;
  localparam logic [7:0] IDX_TEST_WORD1_HIGH    = 8'h75;
  localparam logic [7:0] IDX_TEST_WORD1_LOW     = 8'h76;
  localparam logic [7:0] IDX_TEST_WORD2_HIGH    = 8'h77;
  localparam logic [7:0] IDX_TEST_WORD2_LOW     = 8'h78;

  // Field positions
  localparam int TUNE_LSB        = 4;
  localparam int MODE_LSB        = 0;
  localparam int UNLOCK1_BIT     = 3;
  localparam int MID_FILT_BIT    = 1;
  localparam int MID_SIGN_BIT    = 0;
  localparam int OUT_FILT_BIT    = 5;
  localparam int OUT_SIGN_BIT    = 4;
  localparam int OUT_TUNE_LSB    = 0;
  localparam int SKIP_LSB        = 0;
  localparam int LOOP_OFF_BIT    = 2;
  localparam int TP_SEL_LSB      = 4;
  localparam int LOW_PART_LSB    = 2;

  // Reset value and skip field codes
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] SKIP_ON    = 2'h3;
  localparam logic [1:0] SKIP_OFF   = 2'h0;

  typedef enum logic [3:0] {
    ACFG_MODE_Q_CPLX   = 4'h0,
    ACFG_MODE_NA1      = 4'h1,
    ACFG_MODE_D2_REAL  = 4'h2,
    ACFG_MODE_NA3      = 4'h3,
    ACFG_MODE_MIX_REAL = 4'h4,
    ACFG_MODE_MIX_CPLX = 4'h5,
    ACFG_MODE_D4_CPLX  = 4'h6,
    ACFG_MODE_MIX_ZINS = 4'h7,
    ACFG_MODE_BURST    = 4'h8
  } acfg_mode_e;

  typedef enum logic [3:0] {
    ACFG_TP_NORMAL = 4'h0,
    ACFG_TP_ZEROS  = 4'h1,
    ACFG_TP_ONES   = 4'h2,
    ACFG_TP_TOGGLE = 4'h3,
    ACFG_TP_RAMP   = 4'h4,
    ACFG_TP_SINGLE = 4'h6,
    ACFG_TP_DOUBLE = 4'h7,
    ACFG_TP_DESKEW = 4'h8
  } acfg_tp_e;
endpackage : acfg_pkg
`default_nettype wire

// [acfg_pat_if.sv]
// Link between the register bank and the test-pattern generator
`timescale 1ns/1ps
`default_nettype none
interface acfg_pat_if #(parameter int WORD_W = 14);
  logic [3:0]        sel;
  logic [WORD_W-1:0] word1;
  logic [WORD_W-1:0] word2;
  logic              sample_en;
  logic [WORD_W-1:0] adc_data;
  logic [WORD_W-1:0] pat_data;
  logic              pat_valid;
  modport cfg (output sel, word1, word2, sample_en, adc_data,
               input pat_data, pat_valid);
  modport gen (input sel, word1, word2, sample_en, adc_data,
               output pat_data, pat_valid);
endinterface : acfg_pat_if
`default_nettype wire

// [acfg_pattern_gen.sv]
// Test-pattern generator shared by all channels
`timescale 1ns/1ps
`default_nettype none
module acfg_pattern_gen #(
  parameter int WORD_W = 14
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Configuration and samples
  acfg_pat_if.gen  pat
);
  typedef struct packed {
    logic [WORD_W-1:0] ramp;
    logic              phase;
    logic [WORD_W-1:0] data;
    logic              valid;
  } acfg_gen_s;

  acfg_gen_s st_q;
  acfg_gen_s st_d;

  always_comb begin
    st_d       = st_q;
    st_d.valid = pat.sample_en;
    if (pat.sample_en) begin
      st_d.phase = ~st_q.phase;
      case (acfg_pkg::acfg_tp_e'(pat.sel))
        acfg_pkg::ACFG_TP_NORMAL: st_d.data = pat.adc_data;
        acfg_pkg::ACFG_TP_ZEROS:  st_d.data = '0;
        acfg_pkg::ACFG_TP_ONES:   st_d.data = '1;
        acfg_pkg::ACFG_TP_TOGGLE: begin
          // Alternating 1010.. and 0101..
          // The repeat is two bits too wide for odd halves; trim on purpose
          st_d.data = WORD_W'({(WORD_W/2 + 1){st_q.phase, ~st_q.phase}});
        end
        acfg_pkg::ACFG_TP_RAMP: begin
          st_d.data = st_q.ramp;
          st_d.ramp = st_q.ramp + 1'b1;
        end
        acfg_pkg::ACFG_TP_SINGLE: st_d.data = pat.word1;
        acfg_pkg::ACFG_TP_DOUBLE: begin
          st_d.data = st_q.phase ? pat.word2 : pat.word1;
        end
        acfg_pkg::ACFG_TP_DESKEW: st_d.data = '1;
        default: st_d.data = pat.adc_data;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign pat.pat_data  = st_q.data;
  assign pat.pat_valid = st_q.valid;
endmodule : acfg_pattern_gen
`default_nettype wire

// [acfg_regs.sv]
// Digital-path configuration register bank with Avalon-MM slave
//
// Our own choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Index 0x75 holds first test word bits 13:6
// - Index 0x76 top six bits: word bits 5:0
// - Second word split likewise at 0x77 and 0x78
// - Both test words shared by every channel
// - Skip field 00 corrects, 11 bypasses correction
// - Bit 2 set stops the offset loop
// - Tune step is signed N, mixer N*fs/16
// - Code 000: quarter-rate mix, decimate 2, complex
// - Code 010: decimate 2 through filter, real
// - Code 100: fine mixer, decimate 2, real
// - Code 101: fine mixer, decimate 2, complex
// - Code 110: decimate 4 complex, needs unlock 111
// - Code 111: fine mixer, zero insert, real
// - Pattern 0110 word1, 0111 alternates both words
// - Filter bit 0 low-pass, 1 high-pass
// - Quarter sign 0 plus, 1 minus
module acfg_regs #(
  parameter int ADDR_W = 10,
  parameter int WORD_W = 14
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              sys_rst,
  // Avalon-MM slave, byte address
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [3:0]        byteenable,
  input  wire logic [31:0]       writedata,
  output logic      [31:0]       readdata,
  output logic                   waitrequest,
  // Shared custom test words
  output logic      [WORD_W-1:0] test_word1,
  output logic      [WORD_W-1:0] test_word2,
  // Interleave correction and offset loop
  output logic                   interleave_fix_skip,
  output logic                   offset_loop_run,
  // Down-conversion setup
  output logic      [3:0]        downconv_select,
  output logic                   downconv_valid,
  output logic                   downconv_decim4,
  output logic                   downconv_complex,
  output logic                   downconv_quarter_mix,
  output logic                   downconv_fine_mix,
  output logic                   downconv_filter_only,
  output logic                   downconv_zero_insert,
  output logic                   downconv_burst,
  output logic                   quad_decim_ready,
  output logic signed [3:0]      mid_pair_tune_step,
  output logic signed [3:0]      outer_pair_tune_step,
  output logic                   mid_pair_highpass,
  output logic                   outer_pair_highpass,
  output logic                   mid_pair_minus_quarter,
  output logic                   outer_pair_minus_quarter,
  // Sample path for the pattern generator
  input  wire logic              sample_en,
  input  wire logic [WORD_W-1:0] adc_data,
  output logic      [WORD_W-1:0] pattern_data,
  output logic                   pattern_valid
);
  localparam int IDX_W = 8;

  initial begin
    if (ADDR_W < IDX_W + 2) begin
      $error("ADDR_W too small for the register map");
    end
    if (WORD_W != 14) begin
      $error("Test word layout serves 14-bit words only");
    end
  end

  typedef struct packed {
    logic [7:0]  setup_bc;
    logic [3:0]  pair_bc;
    logic [5:0]  pair_ad;
    logic [1:0]  fix_skip;
    logic [1:0]  unlock_rest;
    logic        loop_off;
    logic [3:0]  tp_sel;
    logic [7:0]  w1_high;
    logic [5:0]  w1_low;
    logic [7:0]  w2_high;
    logic [5:0]  w2_low;
    logic        ack;
    logic [31:0] rdata;
  } acfg_regs_s;

  acfg_regs_s st_q;
  acfg_regs_s st_d;

  logic [IDX_W-1:0] idx;
  logic             req;
  logic             wr_fire;
  logic [7:0]       wbyte;

  assign idx     = address[IDX_W+1:2];
  assign req     = read | write;
  assign wr_fire = write & st_q.ack & byteenable[0];
  assign wbyte   = writedata[7:0];

  // Low part of a split test word sits above two fixed zeros
  function automatic logic [7:0] low_byte(input logic [5:0] part);
    low_byte = {part, 2'h0};
  endfunction : low_byte

  function automatic logic [7:0] read_byte(input logic [IDX_W-1:0] i,
                                           input acfg_regs_s s);
    read_byte = acfg_pkg::RESET_BYTE;
    case (i)
      acfg_pkg::IDX_DOWNCONV_SETUP_BC: read_byte = s.setup_bc;
      acfg_pkg::IDX_PAIR_SETUP_BC:     read_byte = {4'h0, s.pair_bc};
      acfg_pkg::IDX_PAIR_SETUP_AD:     read_byte = {2'h0, s.pair_ad};
      acfg_pkg::IDX_INTERLEAVE_FIX:    read_byte = {6'h00, s.fix_skip};
      acfg_pkg::IDX_QUAD_UNLOCK_REST:  read_byte = {6'h00, s.unlock_rest};
      acfg_pkg::IDX_OFFSET_LOOP_CTRL: begin
        read_byte = {5'h00, s.loop_off, 2'h0};
      end
      acfg_pkg::IDX_TEST_PATTERN_SEL:  read_byte = {s.tp_sel, 4'h0};
      acfg_pkg::IDX_TEST_WORD1_HIGH:   read_byte = s.w1_high;
      acfg_pkg::IDX_TEST_WORD1_LOW:    read_byte = low_byte(s.w1_low);
      acfg_pkg::IDX_TEST_WORD2_HIGH:   read_byte = s.w2_high;
      acfg_pkg::IDX_TEST_WORD2_LOW:    read_byte = low_byte(s.w2_low);
      default:                         read_byte = acfg_pkg::RESET_BYTE;
    endcase
  endfunction : read_byte

  always_comb begin
    st_d     = st_q;
    // One wait cycle per access; read data is captured as the wait ends
    st_d.ack = req & ~st_q.ack;
    if (req && !st_q.ack) begin
      st_d.rdata = {24'h000000, read_byte(idx, st_q)};
    end
    if (wr_fire) begin
      case (idx)
        acfg_pkg::IDX_DOWNCONV_SETUP_BC: st_d.setup_bc = wbyte;
        acfg_pkg::IDX_PAIR_SETUP_BC:     st_d.pair_bc  = wbyte[3:0];
        acfg_pkg::IDX_PAIR_SETUP_AD:     st_d.pair_ad  = wbyte[5:0];
        acfg_pkg::IDX_INTERLEAVE_FIX: begin
          st_d.fix_skip = wbyte[acfg_pkg::SKIP_LSB +: 2];
        end
        acfg_pkg::IDX_QUAD_UNLOCK_REST:  st_d.unlock_rest = wbyte[1:0];
        acfg_pkg::IDX_OFFSET_LOOP_CTRL: begin
          st_d.loop_off = wbyte[acfg_pkg::LOOP_OFF_BIT];
        end
        acfg_pkg::IDX_TEST_PATTERN_SEL: begin
          st_d.tp_sel = wbyte[acfg_pkg::TP_SEL_LSB +: 4];
        end
        acfg_pkg::IDX_TEST_WORD1_HIGH: st_d.w1_high = wbyte;
        acfg_pkg::IDX_TEST_WORD1_LOW: begin
          st_d.w1_low = wbyte[acfg_pkg::LOW_PART_LSB +: 6];
        end
        acfg_pkg::IDX_TEST_WORD2_HIGH: st_d.w2_high = wbyte;
        acfg_pkg::IDX_TEST_WORD2_LOW: begin
          st_d.w2_low = wbyte[acfg_pkg::LOW_PART_LSB +: 6];
        end
        default: st_d.ack = st_d.ack;
      endcase
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign readdata    = st_q.rdata;
  assign waitrequest = req & ~st_q.ack;

  // Shared test words for every channel
  assign test_word1 = {st_q.w1_high, st_q.w1_low};
  assign test_word2 = {st_q.w2_high, st_q.w2_low};

  // Only 11 bypasses; 01 and 10 are left correcting as the safe reading
  assign interleave_fix_skip = (st_q.fix_skip == acfg_pkg::SKIP_ON);
  assign offset_loop_run     = ~st_q.loop_off;

  // Down-conversion mode decode
  logic [3:0] mode_code;
  logic       unlock_all;

  assign mode_code       = st_q.setup_bc[acfg_pkg::MODE_LSB +: 4];
  assign downconv_select = mode_code;
  assign unlock_all = st_q.pair_bc[acfg_pkg::UNLOCK1_BIT] &
                      (&st_q.unlock_rest);

  always_comb begin
    downconv_valid       = 1'b1;
    downconv_decim4      = 1'b0;
    downconv_complex     = 1'b0;
    downconv_quarter_mix = 1'b0;
    downconv_fine_mix    = 1'b0;
    downconv_filter_only = 1'b0;
    downconv_zero_insert = 1'b0;
    downconv_burst       = 1'b0;
    case (acfg_pkg::acfg_mode_e'(mode_code))
      acfg_pkg::ACFG_MODE_Q_CPLX: begin
        downconv_quarter_mix = 1'b1;
        downconv_complex     = 1'b1;
      end
      acfg_pkg::ACFG_MODE_D2_REAL: begin
        downconv_filter_only = 1'b1;
      end
      acfg_pkg::ACFG_MODE_MIX_REAL: begin
        downconv_fine_mix = 1'b1;
      end
      acfg_pkg::ACFG_MODE_MIX_CPLX: begin
        downconv_fine_mix = 1'b1;
        downconv_complex  = 1'b1;
      end
      acfg_pkg::ACFG_MODE_D4_CPLX: begin
        downconv_fine_mix = 1'b1;
        downconv_complex  = 1'b1;
        downconv_decim4   = 1'b1;
      end
      acfg_pkg::ACFG_MODE_MIX_ZINS: begin
        downconv_fine_mix    = 1'b1;
        downconv_zero_insert = 1'b1;
      end
      acfg_pkg::ACFG_MODE_BURST: begin
        downconv_burst = 1'b1;
      end
      default: begin
        downconv_valid = 1'b0;
      end
    endcase
  end

  // Decimate-by-four is trusted only once every unlock bit is set
  assign quad_decim_ready = downconv_decim4 & unlock_all;

  // Signed tune steps read straight as two's complement N
  assign mid_pair_tune_step =
    signed'(st_q.setup_bc[acfg_pkg::TUNE_LSB +: 4]);
  assign outer_pair_tune_step =
    signed'(st_q.pair_ad[acfg_pkg::OUT_TUNE_LSB +: 4]);

  // Filter and quarter-sign bits only matter in their own modes
  assign mid_pair_highpass = downconv_filter_only &
    st_q.pair_bc[acfg_pkg::MID_FILT_BIT];
  assign outer_pair_highpass = downconv_filter_only &
    st_q.pair_ad[acfg_pkg::OUT_FILT_BIT];
  assign mid_pair_minus_quarter = downconv_quarter_mix &
    st_q.pair_bc[acfg_pkg::MID_SIGN_BIT];
  assign outer_pair_minus_quarter = downconv_quarter_mix &
    st_q.pair_ad[acfg_pkg::OUT_SIGN_BIT];

  // Test-pattern generator
  acfg_pat_if #(.WORD_W(WORD_W)) pat ();

  assign pat.sel       = st_q.tp_sel;
  assign pat.word1     = test_word1;
  assign pat.word2     = test_word2;
  assign pat.sample_en = sample_en;
  assign pat.adc_data  = adc_data;

  acfg_pattern_gen #(.WORD_W(WORD_W)) u_pattern_gen (
    .clk     (clk),
    .sys_rst (sys_rst),
    .pat     (pat.gen)
  );

  assign pattern_data  = pat.pat_data;
  assign pattern_valid = pat.pat_valid;
endmodule : acfg_regs
`default_nettype wire

// [acfg_regs_properties.sv]
// Bus timing and field decode properties of the config register bank
`timescale 1ns/1ps
`default_nettype none
module acfg_regs_properties #(
  parameter int ADDR_W = 10,
  parameter int WORD_W = 14
) (
  // Clock, reset and bus
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic [ADDR_W-1:0] address,
  input wire logic              read,
  input wire logic              write,
  input wire logic [3:0]        byteenable,
  input wire logic [31:0]       writedata,
  input wire logic [31:0]       readdata,
  input wire logic              waitrequest,
  // Decoded configuration
  input wire logic [WORD_W-1:0] test_word1,
  input wire logic [WORD_W-1:0] test_word2,
  input wire logic              interleave_fix_skip,
  input wire logic              offset_loop_run,
  input wire logic [3:0]        downconv_select,
  input wire logic              downconv_complex,
  input wire logic              downconv_quarter_mix,
  input wire logic              downconv_decim4,
  input wire logic signed [3:0] mid_pair_tune_step,
  // Pattern path
  input wire logic              sample_en,
  input wire logic              pattern_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Byte-lane write that completes at this edge
  sequence s_wr(int idx);
    write && !waitrequest && byteenable[0] && (address >> 2) == idx;
  endsequence
  sequence s_req_wait;
    (read || write) && waitrequest;
  endsequence
  a_one_wait: assert property (s_req_wait |=> !waitrequest)
    else $error("request not answered after one wait cycle");
  a_word1_high: assert property (s_wr(8'h75) |=>
    test_word1[13:6] == $past(writedata[7:0])) else $error("word1 high");
  a_word1_low: assert property (s_wr(8'h76) |=>
    test_word1[5:0] == $past(writedata[7:2])) else $error("word1 low");
  a_word2_high: assert property (s_wr(8'h77) |=>
    test_word2[13:6] == $past(writedata[7:0])) else $error("word2 high");
  a_word2_low: assert property (s_wr(8'h78) |=>
    test_word2[5:0] == $past(writedata[7:2])) else $error("word2 low");
  a_skip_decode: assert property (s_wr(8'h18) |=>
    interleave_fix_skip == ($past(writedata[1:0]) == 2'h3))
    else $error("skip decode wrong");
  a_loop_stop: assert property (s_wr(8'h68) |=>
    offset_loop_run == !$past(writedata[2])) else $error("loop control");
  a_tune_field: assert property (s_wr(8'h00) |=>
    mid_pair_tune_step == $past(writedata[7:4])) else $error("tune step");
  a_mode_zero: assert property (downconv_select == 4'h0 |->
    downconv_quarter_mix && downconv_complex) else $error("mode 0 decode");
  a_mode_two: assert property (downconv_select == 4'h2 |->
    !downconv_complex && !downconv_quarter_mix) else $error("mode 2 decode");
  a_mode_six: assert property (downconv_select == 4'h6 |->
    downconv_decim4 && downconv_complex) else $error("mode 6 decode");
  a_read_upper: assert property (read && !waitrequest |->
    readdata[31:8] == 24'h0) else $error("read upper bits set");
  a_valid_pulse: assert property (1'b1 |=>
    pattern_valid == $past(sample_en)) else $error("pattern valid timing");
endmodule : acfg_regs_properties
bind acfg_regs acfg_regs_properties #(.ADDR_W(ADDR_W), .WORD_W(WORD_W)) chk_u (
  .clk(clk), .sys_rst(sys_rst), .address(address), .read(read),
  .write(write), .byteenable(byteenable), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .test_word1(test_word1),
  .test_word2(test_word2), .interleave_fix_skip(interleave_fix_skip),
  .offset_loop_run(offset_loop_run), .downconv_select(downconv_select),
  .downconv_complex(downconv_complex), .downconv_decim4(downconv_decim4),
  .downconv_quarter_mix(downconv_quarter_mix), .sample_en(sample_en),
  .mid_pair_tune_step(mid_pair_tune_step), .pattern_valid(pattern_valid));
`default_nettype wire

// [adc_digital_path_config_tb.sv]
// Self-checking bench for the config register bank
`timescale 1ns/1ps
`default_nettype none
module adc_digital_path_config_tb;
  logic              clk = 1'b0;
  logic              sys_rst, read, write, sample_en;
  logic [9:0]        address;
  logic [3:0]        byteenable, downconv_select;
  logic [31:0]       writedata, readdata;
  logic [13:0]       test_word1, test_word2, adc_data, pattern_data;
  logic              waitrequest, interleave_fix_skip, offset_loop_run;
  logic              downconv_valid, downconv_decim4, downconv_complex;
  logic              downconv_quarter_mix, downconv_fine_mix, downconv_burst;
  logic              downconv_filter_only, downconv_zero_insert;
  logic              quad_decim_ready, mid_pair_highpass, pattern_valid;
  logic              mid_pair_minus_quarter, outer_pair_minus_quarter;
  logic              outer_pair_highpass;
  logic signed [3:0] mid_pair_tune_step, outer_pair_tune_step;
  logic [3:0]        ot;
  logic [31:0]       rng = 32'hccb9b2bd;
  logic [31:0]       exp_q[$];
  logic [13:0]       pat_q[$];
  logic [7:0]        w[4];
  logic [12:0]       f;
  logic [7:0]        idx_l[7] = '{8'h00, 8'h18, 8'h68, 8'h75, 8'h76, 8'h77,
                                  8'h78};
  int                error_cnt = 0;
  int                samples_checked = 0;

  always #50 clk = ~clk;

  acfg_regs dut_u (.clk, .sys_rst, .address, .read, .write, .byteenable,
    .writedata, .readdata, .waitrequest, .test_word1, .test_word2,
    .interleave_fix_skip, .offset_loop_run, .downconv_select,
    .downconv_valid, .downconv_decim4, .downconv_complex,
    .downconv_quarter_mix, .downconv_fine_mix, .downconv_filter_only,
    .downconv_zero_insert, .downconv_burst, .quad_decim_ready,
    .mid_pair_tune_step, .outer_pair_tune_step, .mid_pair_highpass,
    .outer_pair_highpass, .mid_pair_minus_quarter,
    .outer_pair_minus_quarter, .sample_en, .adc_data, .pattern_data,
    .pattern_valid);

  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // Holds the request until a rising edge samples waitrequest low
  task automatic bus(logic wr, logic [7:0] idx, logic [7:0] d,
                     logic [7:0] e = 8'h00, logic be = 1'b1);
    int n;
    @(posedge clk);
    address    <= {idx, 2'b00};
    writedata  <= {24'h0, d};
    byteenable <= {3'b000, be};
    write      <= wr;
    read       <= !wr;
    if (!wr) exp_q.push_back({24'h0, e});
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 20);
    if (waitrequest !== 1'b0) begin
      error_cnt++;
      $display("[ERR] waitrequest expected 0 seen %b", waitrequest);
      tally_and_finish();
    end
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus

  task automatic smp(logic [13:0] e);
    @(posedge clk);
    sample_en <= 1'b1;
    adc_data  <= rng[13:0];
    pat_q.push_back(e);
    @(posedge clk);
    sample_en <= 1'b0;
  endtask : smp

  // Results are matched against the oldest note when they appear
  always @(negedge clk) begin
    if (read && waitrequest === 1'b0 && exp_q.size() > 0) begin
      chk("readdata", exp_q.pop_front(), readdata);
    end
    if (pattern_valid === 1'b1) begin
      chk("pattern_data", {18'h0, pat_q.pop_front()},
        {18'h0, pattern_data});
    end
  end

  initial begin
    {read, write, sample_en, address, byteenable, writedata, adc_data} = '0;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    foreach (idx_l[i]) bus(1'b0, idx_l[i], 8'h00);
    @(negedge clk);
    chk("reset_outputs", 32'h7, {test_word1, test_word2, interleave_fix_skip,
      offset_loop_run, downconv_quarter_mix, downconv_complex});
    for (int i = 3; i < 7; i++) begin
      rng = xs(rng);
      w[i-3] = rng[7:0];
      bus(1'b1, idx_l[i], rng[7:0]);
    end
    for (int i = 3; i < 7; i++) begin
      bus(1'b0, idx_l[i], 8'h0, w[i-3] & (i[0] ? 8'hff : 8'hfc));
    end
    @(negedge clk);
    chk("test_words", {4'h0, w[0], w[1][7:2], w[2], w[3][7:2]},
      {4'h0, test_word1, test_word2});
    bus(1'b1, 8'h18, 8'h03);
    bus(1'b1, 8'h74, 8'h70);
    smp({w[0], w[1][7:2]});
    smp({w[2], w[3][7:2]});
    bus(1'b1, 8'h74, 8'h60);
    smp({w[0], w[1][7:2]});
    bus(1'b1, 8'h74, 8'h80);
    smp(14'h3fff);
    bus(1'b1, 8'h74, 8'h10);
    smp(14'h0000);
    bus(1'b1, 8'h74, 8'h20);
    smp(14'h3fff);
    bus(1'b1, 8'h74, 8'h40);
    smp(14'h0000);
    smp(14'h0001);
    bus(1'b1, 8'h74, 8'h00);
    rng = xs(rng);
    smp(rng[13:0]);
    for (int v = 0; v < 4; v++) begin
      bus(1'b1, 8'h18, 8'(v));
      @(negedge clk);
      chk("skip", {31'h0, v == 3}, {31'h0, interleave_fix_skip});
    end
    bus(1'b1, 8'h68, 8'h04);
    bus(1'b1, 8'h68, 8'h00, 8'h00, 1'b0);
    @(negedge clk);
    chk("loop_run", 32'h0, {31'h0, offset_loop_run});
    bus(1'b1, 8'h68, 8'h00);
    bus(1'b0, 8'h68, 8'h00, 8'h00);
    bus(1'b1, 8'h55, 8'hff);
    bus(1'b0, 8'h55, 8'h00, 8'h00);
    bus(1'b1, 8'h01, 8'h0b);
    bus(1'b1, 8'h40, 8'h03);
    rng = xs(rng);
    ot = rng[3:0];
    bus(1'b1, 8'h02, {4'h3, ot});
    bus(1'b0, 8'h02, 8'h00, {4'h3, ot});
    bus(1'b0, 8'h01, 8'h00, 8'h0b);
    for (int c = 0; c < 16; c++) begin
      rng = xs(rng);
      bus(1'b1, 8'h00, {rng[3:0], 4'(c)});
      f = {c != 1 && c != 3 && c < 9, c == 0, c == 0 || c == 5 || c == 6,
           c == 2, c > 3 && c < 8, c == 6, c == 7, c == 8, c == 6, c == 2,
           c == 0, c == 2, c == 0};
      @(negedge clk);
      chk("tune", {24'h0, ot, rng[3:0]},
        {24'h0, outer_pair_tune_step, mid_pair_tune_step});
      chk("decode",
        {20'h0, 4'(c), f[12:5]}, {20'h0, downconv_select, downconv_valid,
        downconv_quarter_mix, downconv_complex, downconv_filter_only,
        downconv_fine_mix, downconv_decim4, downconv_zero_insert,
        downconv_burst});
      chk("pair_flags",
        {27'h0, f[4:0]}, {27'h0, quad_decim_ready, mid_pair_highpass,
        mid_pair_minus_quarter, outer_pair_highpass,
        outer_pair_minus_quarter});
    end
    repeat (2) @(posedge clk);
    // Every noted result must have been matched by now
    chk("queues_left", 32'h0, pat_q.size() + exp_q.size());
    tally_and_finish();
  end
endmodule : adc_digital_path_config_tb
`default_nettype wire
